// *** design/stc_pkg.sv ***
// Constants, register map and field layout of the 16-bit timer/counter.
// Assumes an APB slave in front of the registers and a single 20 MHz clock.
//
// Contract
// - Sixteen-bit counter, byte writes update live count
// - Clock select: instruction clock or external pin
// - Internal source advances once per N cycles
// - External rising edges counted after prescaler
// - Sync-disable counts external edges asynchronously
// - Counter mode waits for falling edge first
// - Prescaler divides by one, two, four, eight
// - Prescaler hidden; cleared on count writes
// - Crystal oscillator runs while enabled, through sleep
// - Oscillator allowed only with suitable system clock
// - Oscillator forces shared pins to input
// - Asynchronous counting survives sleep, overflow wakes
// - Sync mode change may gain or lose one
// - No capture/compare time base when asynchronous
// - Rollover sets sticky overflow flag
// - Prescale codes 11,10,01,00 give 8,4,2,1
// - Run bit one counts, zero stops
// - Internal source ignores sync-disable bit
package stc_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CNT_LO = 8'h00;
  localparam logic [7:0] OFF_CNT_HI = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_PORT = 8'h10;
  // ==========================================================
  // Control register fields
  localparam int CTRL_W = 6;
  localparam int CB_RUN = 0;
  localparam int CB_SEL = 1;
  localparam int CB_NSYNC = 2;
  localparam int CB_OSC = 3;
  localparam int CB_PS_LO = 4;
  localparam int CB_PS_HI = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  // ==========================================================
  // Status and port register fields
  localparam int SB_OVF = 0;
  localparam int PB_DIR_A = 0;
  localparam int PB_DIR_B = 1;
  localparam int PB_DAT_A = 2;
  localparam int PB_DAT_B = 3;
  localparam logic [1:0] DIR_RST = 2'h3;
  localparam logic [1:0] LAT_RST = 2'h0;
  // ==========================================================
  // Timing and counts
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // Last prescale count for a select code: 0,1,3,7
  function automatic logic [2:0] ps_last(input logic [1:0] ps);
    unique case (ps)
      2'h0: ps_last = 3'h0;
      2'h1: ps_last = 3'h1;
      2'h2: ps_last = 3'h3;
      2'h3: ps_last = 3'h7;
    endcase
  endfunction : ps_last

  // Address hit on one register word
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit
endpackage : stc_pkg

// *** design/stc_prescaler.sv ***
// Prescale counter: passes one of every N input pulses.
// Assumes in_pulse is a one-cycle pulse on clk; clr has priority.
`timescale 1ns/1ns
`default_nettype none
module stc_prescaler
  import stc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic [1:0] ps_sel,
  input wire logic in_pulse,
  output logic tick
);
  // ==========================================================
  // Counter
  logic [2:0] cnt_r;
  logic wrap;

  // Wrap when the count reaches the selected last value
  assign wrap = (cnt_r >= ps_last(ps_sel));
  assign tick = in_pulse & wrap & ~clr;

  // Count input pulses, cleared by count writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
    end else if (clr) begin
      cnt_r <= 3'h0;
    end else if (in_pulse) begin
      cnt_r <= wrap ? 3'h0 : cnt_r + 3'h1;
    end
  end

  // ==========================================================
  // Checks
  ps_clear_a: assert property (@(posedge clk) disable iff (!rst_n) clr |=> cnt_r == 3'h0)
    else $error("prescaler not cleared by count write");
  ps_div_a: assert property (@(posedge clk) disable iff (!rst_n)
    (in_pulse && !clr && ps_sel == 2'h3 && cnt_r == 3'h0) |-> !tick)
    else $error("divide by eight ticked early");
endmodule : stc_prescaler
`default_nettype wire

// *** design/stc_timer.sv ***
// Sixteen-bit timer/counter with APB registers and crystal pin control.
// Assumes clk is the 20 MHz oscillator; pins and sleep come from outside.
`timescale 1ns/1ns
`default_nettype none
module stc_timer
  import stc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_clock_pin,
  input wire logic sleep_in,
  input wire logic lp_clock_ok,
  input wire logic shared_pin_a_in,
  output logic shared_pin_a_out,
  output logic shared_pin_a_oe,
  input wire logic shared_pin_b_in,
  output logic shared_pin_b_out,
  output logic shared_pin_b_oe,
  output logic crystal_osc_run,
  output logic overflow_flag,
  output logic wake_req,
  output logic timebase_valid,
  output logic [15:0] count_value
);
  // ==========================================================
  // Declarations
  logic [15:0] count_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic flag_r;
  logic wake_r;
  logic osc_run_r;
  logic tb_valid_r;
  logic [1:0] dir_r;
  logic [1:0] lat_r;
  logic oe_a_r;
  logic oe_b_r;
  logic [1:0] q_cnt_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_d_r;
  logic pa_s1_r;
  logic pa_s2_r;
  logic pb_s1_r;
  logic pb_s2_r;
  logic armed_r;
  logic pend_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic osc_run_nxt;
  logic run;
  logic sel;
  logic nsync;
  logic ext_sync;
  logic ext_async;
  logic q_en;
  logic ext_rise;
  logic ext_fall;
  logic ps_in;
  logic tick;
  logic inc;
  logic ovf;
  logic apb_wr;
  logic setup;
  logic lo_wr;
  logic hi_wr;
  logic cnt_wr;
  logic ctrl_wr;
  logic stat_wr;
  logic port_wr;
  logic mapped;

  // ==========================================================
  // Control fields
  assign run = ctrl_r[CB_RUN];
  assign sel = ctrl_r[CB_SEL];
  assign nsync = ctrl_r[CB_NSYNC];
  assign ext_sync = sel & ~nsync;
  assign ext_async = sel & nsync;

  // ==========================================================
  // APB decode
  assign setup = psel & ~penable;
  assign apb_wr = psel & penable & pready_r & pwrite;
  assign lo_wr = apb_wr & reg_hit(paddr, OFF_CNT_LO);
  assign hi_wr = apb_wr & reg_hit(paddr, OFF_CNT_HI);
  assign ctrl_wr = apb_wr & reg_hit(paddr, OFF_CTRL);
  assign stat_wr = apb_wr & reg_hit(paddr, OFF_STAT);
  assign port_wr = apb_wr & reg_hit(paddr, OFF_PORT);
  assign cnt_wr = lo_wr | hi_wr;
  assign mapped = reg_hit(paddr, OFF_CNT_LO) | reg_hit(paddr, OFF_CNT_HI) | reg_hit(paddr, OFF_CTRL)
                | reg_hit(paddr, OFF_STAT) | reg_hit(paddr, OFF_PORT);

  // Ready and error answer in the access phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
    end
  end

  // Read mux; pins show forced values while the oscillator runs
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (reg_hit(paddr, OFF_CNT_LO)) begin
      rd_nxt[7:0] = count_r[7:0];
    end else if (reg_hit(paddr, OFF_CNT_HI)) begin
      rd_nxt[7:0] = count_r[15:8];
    end else if (reg_hit(paddr, OFF_CTRL)) begin
      rd_nxt[CTRL_W-1:0] = ctrl_r;
    end else if (reg_hit(paddr, OFF_STAT)) begin
      rd_nxt[SB_OVF] = flag_r;
    end else if (reg_hit(paddr, OFF_PORT)) begin
      rd_nxt[PB_DIR_A] = dir_r[0] | osc_run_r;
      rd_nxt[PB_DIR_B] = dir_r[1] | osc_run_r;
      rd_nxt[PB_DAT_A] = pa_s2_r & ~osc_run_r;
      rd_nxt[PB_DAT_B] = pb_s2_r & ~osc_run_r;
    end
  end

  // Read data captured at the setup edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_r <= rd_nxt;
    end
  end

  // Control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= pwdata[CTRL_W-1:0];
    end
  end

  // ==========================================================
  // Instruction clock enable, frozen during sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_cnt_r <= 2'h0;
    end else begin
      q_cnt_r <= q_cnt_r + 2'h1;
    end
  end
  assign q_en = (q_cnt_r == Q_LAST) & ~sleep_in;

  // ==========================================================
  // Pin synchronisers and external edge detect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r <= 1'b0;
      pa_s1_r <= 1'b0;
      pa_s2_r <= 1'b0;
      pb_s1_r <= 1'b0;
      pb_s2_r <= 1'b0;
    end else begin
      ext_s1_r <= external_count_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
      pa_s1_r <= shared_pin_a_in;
      pa_s2_r <= pa_s1_r;
      pb_s1_r <= shared_pin_b_in;
      pb_s2_r <= pb_s1_r;
    end
  end
  assign ext_rise = ext_s2_r & ~ext_d_r;
  assign ext_fall = ~ext_s2_r & ext_d_r;

  // Arm on a falling edge; disarm at reset, count write, fall while stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (cnt_wr) begin
      armed_r <= 1'b0;
    end else if (ext_fall) begin
      armed_r <= run;
    end
  end

  // ==========================================================
  // Prescaler input and increment
  assign ps_in = run & (sel ? (ext_rise & armed_r) : q_en);

  stc_prescaler u_ps (
    .clk(clk),
    .rst_n(rst_n),
    .clr(cnt_wr),
    .ps_sel(ctrl_r[CB_PS_HI:CB_PS_LO]),
    .in_pulse(ps_in),
    .tick(tick)
  );

  // Synchronous mode holds a tick until the next instruction cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
    end else if (!ext_sync || cnt_wr || q_en) begin
      pend_r <= 1'b0;
    end else if (tick) begin
      pend_r <= 1'b1;
    end
  end
  assign inc = run & (ext_sync ? (q_en & (pend_r | tick)) : tick);
  assign ovf = inc & (count_r == CNT_MAX) & ~cnt_wr;

  // Live count; byte writes win over increments
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= CNT_RST;
    end else if (lo_wr) begin
      count_r[7:0] <= pwdata[7:0];
    end else if (hi_wr) begin
      count_r[15:8] <= pwdata[7:0];
    end else if (inc) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // Sticky overflow flag, set wins over write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (ovf) begin
      flag_r <= 1'b1;
    end else if (stat_wr && pwdata[SB_OVF]) begin
      flag_r <= 1'b0;
    end
  end

  // Wake pulse on overflow in sleep, asynchronous mode only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= ovf & sleep_in & ext_async;
    end
  end

  // ==========================================================
  // Oscillator, time base and shared pins
  assign osc_run_nxt = ctrl_r[CB_OSC] & lp_clock_ok;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_run_r <= 1'b0;
      tb_valid_r <= 1'b1;
      oe_a_r <= 1'b0;
      oe_b_r <= 1'b0;
    end else begin
      osc_run_r <= osc_run_nxt;
      tb_valid_r <= ~ext_async;
      oe_a_r <= ~osc_run_nxt & ~dir_r[0];
      oe_b_r <= ~osc_run_nxt & ~dir_r[1];
    end
  end

  // Port direction and output latches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= DIR_RST;
      lat_r <= LAT_RST;
    end else if (port_wr) begin
      dir_r <= {pwdata[PB_DIR_B], pwdata[PB_DIR_A]};
      lat_r <= {pwdata[PB_DAT_B], pwdata[PB_DAT_A]};
    end
  end

  // Outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign shared_pin_a_out = lat_r[0];
  assign shared_pin_b_out = lat_r[1];
  assign shared_pin_a_oe = oe_a_r;
  assign shared_pin_b_oe = oe_b_r;
  assign crystal_osc_run = osc_run_r;
  assign overflow_flag = flag_r;
  assign wake_req = wake_r;
  assign timebase_valid = tb_valid_r;
  assign count_value = count_r;

  // ==========================================================
  // Checks
  wr_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    lo_wr |=> count_r[7:0] == $past(pwdata[7:0]))
    else $error("low byte write lost");
  int_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (run && !sel && ctrl_r[CB_PS_HI:CB_PS_LO] == 2'h0 && q_en && !cnt_wr)
    |=> count_r == $past(count_r) + 16'h0001)
    else $error("internal count missed an instruction cycle");
  stop_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!run && !cnt_wr) |=> $stable(count_r))
    else $error("count moved while stopped");
  arm_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel && !nsync && !armed_r && !pend_r && !cnt_wr) |=> $stable(count_r))
    else $error("counted before falling edge");
  flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (inc && count_r == CNT_MAX && !cnt_wr) |=> flag_r && count_r == CNT_RST)
    else $error("rollover did not set flag");
  flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (flag_r && !(stat_wr && pwdata[SB_OVF])) |=> flag_r)
    else $error("flag cleared without software");
  pin_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    osc_run_r |-> !shared_pin_a_oe && !shared_pin_b_oe)
    else $error("shared pin driven while oscillator runs");
  sync_ign_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!sel ##1 !sel) |-> timebase_valid)
    else $error("internal source lost time base");
  wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ovf && sleep_in && ext_async) |=> wake_req ##1 !wake_req)
    else $error("no wake pulse on sleep overflow");
  osc_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
    !lp_clock_ok |=> !crystal_osc_run)
    else $error("oscillator ran without a suitable clock");

  ovf_c: cover property (@(posedge clk) disable iff (!rst_n) ovf);
  wake_c: cover property (@(posedge clk) disable iff (!rst_n) wake_r);
  ext_c: cover property (@(posedge clk) disable iff (!rst_n) inc && sel);
  osc_c: cover property (@(posedge clk) disable iff (!rst_n) osc_run_r && pready_r);
endmodule : stc_timer
`default_nettype wire

// *** tb/stc_ext_src.sv ***
// External count clock source standing beside the timer.
// Assumes go is a one-cycle request on clk while busy is low.
`timescale 1ns/1ns
`default_nettype none
module stc_ext_src (
  input wire logic clk,
  input wire logic go,
  input wire logic lvl,
  input wire logic [3:0] hp,
  input wire logic [7:0] n,
  output logic pin,
  output logic busy
);
  int cnt;
  int tgl;
  // ====
  // Idle at lvl; a request gives 2n toggles, hp+1 cycles apart
  initial begin
    pin = 1'b1;
    busy = 1'b0;
  end
  always @(posedge clk) begin
    if (!busy) begin
      pin <= lvl;
      if (go) begin
        busy <= 1'b1;
        tgl <= 2 * n;
        cnt <= hp;
      end
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (tgl != 0) begin
      pin <= ~pin; // Slow or prompt edges set by hp
      tgl <= tgl - 1;
      cnt <= hp;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule : stc_ext_src
`default_nettype wire

// *** tb/stc_timer_test.sv ***
// Self-checking bench for the 16-bit timer/counter.
// Assumes stc_ext_src drives the count pin; the bench is APB master.
`timescale 1ns/1ns
`default_nettype none
module stc_timer_test
  import stc_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, sleep_in, lp_ok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, ext_a, ext_b, pin_a, pin_b;
  logic a_out, a_oe, b_out, b_oe, osc_run, ovf, wake, tbv;
  logic [15:0] cnt;
  logic src_go, src_lvl, src_pin, src_busy;
  logic [3:0] src_hp;
  logic [7:0] src_n;
  logic [31:0] q[$];
  int num_errors, cmp_count, wakes, n;
  integer seed = 32'h4a53ec6f;
  // ====
  // Pin level: the timer's own drive wins over the board
  assign pin_a = a_oe ? a_out : ext_a;
  assign pin_b = b_oe ? b_out : ext_b;
  stc_timer u_stc_timer (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_clock_pin(src_pin), .sleep_in(sleep_in),
    .lp_clock_ok(lp_ok), .shared_pin_a_in(pin_a), .shared_pin_a_out(a_out),
    .shared_pin_a_oe(a_oe), .shared_pin_b_in(pin_b), .shared_pin_b_out(b_out),
    .shared_pin_b_oe(b_oe), .crystal_osc_run(osc_run), .overflow_flag(ovf),
    .wake_req(wake), .timebase_valid(tbv), .count_value(cnt));
  stc_ext_src u_stc_ext_src (.clk(clk), .go(src_go), .lvl(src_lvl), .hp(src_hp),
    .n(src_n), .pin(src_pin), .busy(src_busy));
  // ====
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // Each read answer is compared with the oldest expected value
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      check("prdata", prdata, q.pop_front());
      check("pslverr", pslverr, paddr > OFF_PORT);
    end
  end
  always @(posedge clk) if (wake === 1'b1) wakes++;
  // ====
  // APB transfer held until pready is sampled high; one idle cycle after it
  // keeps the next call from raising psel in the step that lowered it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_chg(output int m);
    logic [15:0] v;
    v = cnt;
    m = 0;
    do begin
      @(posedge clk);
      m++;
    end while (cnt === v && m < 300);
  endtask : wait_chg
  // External run from start count s: c is the control value, l the idle level
  task automatic ext_run(input logic [5:0] c, input logic l, input int m,
                         input logic [15:0] e, input logic [15:0] s);
    wr(OFF_CTRL, {26'h0, c[5:1], 1'b0});
    src_lvl <= l;
    wr(OFF_CNT_LO, {24'h0, s[7:0]});
    wr(OFF_CNT_HI, {24'h0, s[15:8]});
    wr(OFF_CTRL, {26'h0, c});
    src_hp <= 4'h4 + 4'($random(seed) & 7);
    src_n <= 8'(m);
    src_go <= 1'b1;
    @(posedge clk);
    src_go <= 1'b0;
    do begin
      @(posedge clk);
    end while (src_busy !== 1'b0);
    repeat (12) @(posedge clk);
    check("ext count", cnt, e);
    check("timebase", tbv, !(c[1] && c[2]));
    $display("test ext %h done", c);
  endtask : ext_run
  // ====
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, sleep_in, lp_ok, ext_a, ext_b, src_go, src_lvl} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src_hp = 4'h4;
    src_n = 8'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFF_CTRL, 32'h0);
    rd(OFF_PORT, 32'h3);
    rd(OFF_STAT, 32'h0);
    rd(8'h14, 32'h0);
    wr(OFF_CNT_LO, 32'hA5);
    wr(OFF_CNT_HI, 32'h3C);
    rd(OFF_CNT_LO, 32'hA5);
    rd(OFF_CNT_HI, 32'h3C);
    $display("test reset and bytes done");
    for (int p = 0; p < 4; p++) begin
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CNT_LO, 32'hFE);
      wr(OFF_CNT_HI, 32'hFF);
      wr(OFF_STAT, 32'h1);
      wr(OFF_CTRL, 32'(p << 4) | 32'h1 | (p == 3 ? 32'h4 : 32'h0));
      wait_chg(n);
      wait_chg(n);
      check("period", n, 4 << p);
      check("wrap", cnt, 16'h0000);
      rd(OFF_STAT, 32'h1);
      wr(OFF_STAT, 32'h1);
      rd(OFF_STAT, 32'h0);
      $display("test internal %0d done", p);
    end
    wait_chg(n);
    repeat (10) @(posedge clk);
    wr(OFF_CNT_LO, {24'h0, cnt[7:0]});
    wait_chg(n);
    check("ps clear", n >= 28, 1'b1);
    wr(OFF_CTRL, 32'h0);
    wait_chg(n);
    check("stopped", n, 300);
    ext_run(6'h07, 1'b1, 5, 16'h0005, 16'h0000);
    ext_run(6'h07, 1'b0, 5, 16'h0004, 16'h0000);
    ext_run(6'h13, 1'b1, 6, 16'h0003, 16'h0000);
    ext_run(6'h37, 1'b1, 8, 16'h0001, 16'h0000);
    n = 2 + ($random(seed) & 7);
    ext_run(6'h07, 1'b1, n, 16'(n), 16'h0000);
    wr(OFF_STAT, 32'h1);
    wakes = 0;
    sleep_in <= 1'b1;
    ext_run(6'h07, 1'b1, 3, 16'h0001, 16'hFFFE);
    check("wake", wakes, 1);
    check("sleep flag", ovf, 1'b1);
    sleep_in <= 1'b0;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_PORT, 32'hC);
    repeat (4) @(posedge clk);
    rd(OFF_PORT, 32'hC);
    check("drive", {a_oe, b_oe}, 2'b11);
    r = $random(seed);
    ext_a <= r[0];
    ext_b <= r[1];
    wr(OFF_PORT, 32'h3);
    repeat (4) @(posedge clk);
    rd(OFF_PORT, {28'h0, r[1], r[0], 2'b11});
    $display("test port done");
    ext_a <= 1'b1;
    ext_b <= 1'b1;
    wr(OFF_PORT, 32'hC);
    lp_ok <= 1'b1;
    wr(OFF_CTRL, 32'h8);
    repeat (3) @(posedge clk);
    check("osc on", osc_run, 1'b1);
    check("osc pins", {a_oe, b_oe}, 2'b00);
    rd(OFF_PORT, 32'h3);
    sleep_in <= 1'b1;
    repeat (3) @(posedge clk);
    check("osc sleep", osc_run, 1'b1);
    sleep_in <= 1'b0;
    lp_ok <= 1'b0;
    repeat (3) @(posedge clk);
    check("osc gated", osc_run, 1'b0);
    $display("test oscillator done");
    stop_test();
  end
endmodule : stc_timer_test
`default_nettype wire
